// [src/hss_params.svh]
// Purpose: Constants for the homing switch sequencer
// Assumes: Included by the sequencer only; the package does not include it
// Notes: Step word is {dir_pos, fast, cond[2:0], last}
`ifndef HSS_PARAMS_SVH
`define HSS_PARAMS_SVH

`define HSS_METHOD_NEG_LIM 8'h01
`define HSS_METHOD_POS_LIM 8'h02
`define HSS_METHOD_FIRST_SW 8'h07
`define HSS_METHOD_LAST_SW 8'h0E
`define HSS_METHOD_NEG_EDGE 8'h11
`define HSS_METHOD_POS_EDGE 8'h12

`define HSS_COND_HOME_ON 3'h0
`define HSS_COND_HOME_OFF 3'h1
`define HSS_COND_HOME_PAST 3'h2
`define HSS_COND_IDX_ON 3'h3
`define HSS_COND_IDX_OFF 3'h4
`define HSS_COND_LIM_ON 3'h5
`define HSS_COND_LIM_OFF 3'h6
`define HSS_COND_IDX_LIM_OFF 3'h7

`define HSS_STEP_W 6
`define HSS_STEP_DIR 5
`define HSS_STEP_FAST 4
`define HSS_STEP_COND_LSB 1
`define HSS_STEP_LAST 0
`define HSS_STEPS 4

`define HSS_VAR_A 2'h0
`define HSS_VAR_B 2'h1
`define HSS_VAR_C 2'h2

`define HSS_SPEED_RST 32'h0000_0000

`endif

// [src/hss_pkg.sv]
// Purpose: Types for the homing switch sequencer
// Assumes: No constants used; hss_params.svh is not included here
// Notes: None
package hss_pkg;
   typedef enum logic [1:0] {
      HSS_IDLE = 2'b00,
      HSS_RUN = 2'b01,
      HSS_DONE = 2'b10,
      HSS_FAULT = 2'b11
   } hss_state_t;
endpackage

// [src/hss_sequencer.sv]
// Purpose: Homing sequencer for one servo axis, switch, limit and index methods
// Assumes: Switch and index inputs synchronous to clk_sys_in, active high
// Notes: Method codes 1, 2, 7 to 14, 17 and 18; others end in error
// Overview of operation
// - Method 7, clear start: positive fast to switch, negative slow to index.
// - Method 7 on switch: negative off, positive onto it, negative slow to index.
// - Method 7 positive limit: negative past switch, positive onto it, slow index.
// - Method 8: finish positive slow, index with switch on, after fast negative pass.
// - Method 9: positive past switch, negative slow, index with switch on.
// - Method 10: positive past, negative onto switch, positive slow to index.
// - Method 11: negative to switch, positive slow to index; limit variants differ.
// - Method 12: negative to switch, positive past it, negative slow to index.
// - Method 12 on switch: negative past it, positive slow, index with switch on.
// - Method 13: negative past switch, positive slow to index with switch on.
// - Method 14: negative past, positive onto switch, negative slow to index.
// - Method 17 moves like method 1 but ends on negative limit release.
// - Method 18 moves like method 2 but ends on positive limit release.
// - Unused limit asserting flags error and halts at once.
// - Method 1: negative fast to limit, positive slow to index after release.
// - Method 2: positive fast to limit, negative slow to index after release.
`timescale 1ns/100ps
`include "hss_params.svh"

module hss_sequencer #(
   parameter int SPEED_W = 32
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic start_in,
   input wire logic [7:0] method_in,
   input wire logic [SPEED_W-1:0] fast_speed_in,
   input wire logic [SPEED_W-1:0] slow_speed_in,
   input wire logic home_sw_in,
   input wire logic pos_lim_in,
   input wire logic neg_lim_in,
   input wire logic index_in,
   output logic drive_en_out,
   output logic dir_pos_out,
   output logic [SPEED_W-1:0] speed_out,
   output logic busy_out,
   output logic done_out,
   output logic error_out
);

   // Width of one step word
   localparam int SW = `HSS_STEP_W;

   // One step word
   function automatic logic [SW-1:0] mk(input logic pos, input logic fast,
                                         input logic [2:0] cond, input logic last);
      mk = {pos, fast, cond, last};
   endfunction

   // Step list per method and variant, step 0 in the top bits
   // Unused trailing steps stay zero
   function automatic logic [4*SW-1:0] seq_f(input logic [7:0] m, input logic [1:0] v);
      logic [4*SW-1:0] s;
      s = '0;
      case ({m, v})
         {8'h01, `HSS_VAR_A}, {8'h11, `HSS_VAR_A}:
            s = {mk(1'b0, 1'b1, `HSS_COND_LIM_ON, 1'b0),
                 mk(1'b1, 1'b0, (m == 8'h11) ? `HSS_COND_LIM_OFF : `HSS_COND_IDX_LIM_OFF,
                    1'b1), 12'h000};
         {8'h01, `HSS_VAR_B}, {8'h11, `HSS_VAR_B}:
            s = {mk(1'b1, 1'b1, `HSS_COND_LIM_OFF, 1'b0),
                 mk(1'b0, 1'b1, `HSS_COND_LIM_ON, 1'b0),
                 mk(1'b1, 1'b0, (m == 8'h11) ? `HSS_COND_LIM_OFF : `HSS_COND_IDX_LIM_OFF,
                    1'b1), 6'h00};
         {8'h02, `HSS_VAR_A}, {8'h12, `HSS_VAR_A}:
            s = {mk(1'b1, 1'b1, `HSS_COND_LIM_ON, 1'b0),
                 mk(1'b0, 1'b0, (m == 8'h12) ? `HSS_COND_LIM_OFF : `HSS_COND_IDX_LIM_OFF,
                    1'b1), 12'h000};
         {8'h02, `HSS_VAR_B}, {8'h12, `HSS_VAR_B}:
            s = {mk(1'b0, 1'b1, `HSS_COND_LIM_OFF, 1'b0),
                 mk(1'b1, 1'b1, `HSS_COND_LIM_ON, 1'b0),
                 mk(1'b0, 1'b0, (m == 8'h12) ? `HSS_COND_LIM_OFF : `HSS_COND_IDX_LIM_OFF,
                    1'b1), 6'h00};
         {8'h07, `HSS_VAR_A}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 12'h000};
         {8'h07, `HSS_VAR_B}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h07, `HSS_VAR_C}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h08, `HSS_VAR_A}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_ON, 1'b1), 6'h00};
         {8'h08, `HSS_VAR_B}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h08, `HSS_VAR_C}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h09, `HSS_VAR_A}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h09, `HSS_VAR_B}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h09, `HSS_VAR_C}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_ON, 1'b1), 6'h00};
         {8'h0A, `HSS_VAR_A}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h0A, `HSS_VAR_B}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h0A, `HSS_VAR_C}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 12'h000};
         {8'h0B, `HSS_VAR_A}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 12'h000};
         {8'h0B, `HSS_VAR_B}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h0B, `HSS_VAR_C}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h0C, `HSS_VAR_A}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b1, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_ON, 1'b1), 6'h00};
         {8'h0C, `HSS_VAR_B}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h0C, `HSS_VAR_C}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h0D, `HSS_VAR_A}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h0D, `HSS_VAR_B}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_ON, 1'b1), 12'h000};
         {8'h0D, `HSS_VAR_C}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b1, 1'b0, `HSS_COND_IDX_ON, 1'b1), 6'h00};
         {8'h0E, `HSS_VAR_A}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_PAST, 1'b0),
                 mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h0E, `HSS_VAR_B}:
            s = {mk(1'b0, 1'b1, `HSS_COND_HOME_OFF, 1'b0),
                 mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 6'h00};
         {8'h0E, `HSS_VAR_C}:
            s = {mk(1'b1, 1'b1, `HSS_COND_HOME_ON, 1'b0),
                 mk(1'b0, 1'b0, `HSS_COND_IDX_OFF, 1'b1), 12'h000};
         default:
            s = '0;
      endcase
      seq_f = s;
   endfunction

   // Sequencer state
   hss_pkg::hss_state_t state_q;
   hss_pkg::hss_state_t state_d;
   logic start_q;
   logic [1:0] var_q;
   logic [1:0] var_d;
   logic [1:0] idx_q;
   logic [1:0] idx_d;
   logic seen_q;
   logic seen_d;
   logic dir_q;
   logic en_q;

   // Method classes
   wire logic sw_method = (method_in >= `HSS_METHOD_FIRST_SW) &&
                          (method_in <= `HSS_METHOD_LAST_SW);
   wire logic neg_side = (method_in == `HSS_METHOD_NEG_LIM) ||
                         (method_in == `HSS_METHOD_NEG_EDGE) ||
                         (method_in >= 8'h0B && method_in <= `HSS_METHOD_LAST_SW);
   // Limit the method runs to, and the one that must stay clear
   wire logic lim_used = neg_side ? neg_lim_in : pos_lim_in;
   wire logic lim_other = neg_side ? pos_lim_in : neg_lim_in;
   wire logic lim_method = !sw_method;
   wire logic known = sw_method || (method_in == `HSS_METHOD_NEG_LIM) ||
                      (method_in == `HSS_METHOD_POS_LIM) ||
                      (method_in == `HSS_METHOD_NEG_EDGE) ||
                      (method_in == `HSS_METHOD_POS_EDGE);
   // Start edge and variant picked from the switches at start
   wire logic start_edge = start_in && !start_q;
   wire logic [1:0] start_var = (lim_method ? lim_used : home_sw_in) ?
                                `HSS_VAR_B : `HSS_VAR_A;

   // Current step
   wire logic [4*SW-1:0] seq_w = seq_f(method_in, var_q);
   wire logic [SW-1:0] step_w = seq_w[(3 - idx_q) * SW +: SW];
   wire logic [2:0] cond_w = step_w[`HSS_STEP_COND_LSB +: 3];
   wire logic step_last = step_w[`HSS_STEP_LAST];

   // Condition that ends the step in force
   logic cond_met;
   always_comb begin
      case (cond_w)
         `HSS_COND_HOME_ON: cond_met = home_sw_in;
         `HSS_COND_HOME_OFF: cond_met = !home_sw_in;
         `HSS_COND_HOME_PAST: cond_met = seen_q && !home_sw_in;
         `HSS_COND_IDX_ON: cond_met = index_in && home_sw_in;
         `HSS_COND_IDX_OFF: cond_met = index_in && !home_sw_in;
         `HSS_COND_LIM_ON: cond_met = lim_used;
         `HSS_COND_LIM_OFF: cond_met = !lim_used;
         default: cond_met = index_in && !lim_used;
      endcase
   end

   // Sequencing
   always_comb begin
      state_d = state_q;
      var_d = var_q;
      idx_d = idx_q;
      seen_d = seen_q || home_sw_in;
      case (state_q)
         hss_pkg::HSS_RUN: begin
            if (lim_other) begin
               state_d = hss_pkg::HSS_FAULT;
            end else if (sw_method && var_q == `HSS_VAR_A && lim_used) begin
               var_d = `HSS_VAR_C;
               idx_d = 2'h0;
               seen_d = 1'b0;
            end else if (cond_met) begin
               if (step_last) begin
                  state_d = hss_pkg::HSS_DONE;
               end else begin
                  idx_d = idx_q + 2'h1;
                  seen_d = 1'b0;
               end
            end
         end
         default: begin
            if (start_edge) begin
               state_d = known ? hss_pkg::HSS_RUN : hss_pkg::HSS_FAULT;
               var_d = start_var;
               idx_d = 2'h0;
               seen_d = 1'b0;
            end
         end
      endcase
   end

   // Step pointer and start edge registers
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= hss_pkg::HSS_IDLE;
         start_q <= 1'b0;
         var_q <= `HSS_VAR_A;
         idx_q <= 2'h0;
         seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         start_q <= start_in;
         var_q <= var_d;
         idx_q <= idx_d;
         seen_q <= seen_d;
      end
   end

   // Drive command from the step in force
   wire logic [4*SW-1:0] next_seq = seq_f(method_in, var_d);
   wire logic [SW-1:0] next_step = next_seq[(3 - idx_d) * SW +: SW];
   wire logic run_d = (state_d == hss_pkg::HSS_RUN);
   wire logic dir_d = next_step[`HSS_STEP_DIR];
   // Speed value for the step in force, zero when halted
   wire logic [SPEED_W-1:0] speed_d = !run_d ? SPEED_W'(`HSS_SPEED_RST) :
                                     next_step[`HSS_STEP_FAST] ? fast_speed_in :
                                     slow_speed_in;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         en_q <= 1'b0;
         dir_q <= 1'b0;
         speed_out <= SPEED_W'(`HSS_SPEED_RST);
      end else begin
         en_q <= run_d;
         dir_q <= dir_d;
         speed_out <= speed_d;
      end
   end

   // Run, done and fault status decoded from the state
   assign drive_en_out = en_q;
   assign dir_pos_out = dir_q;
   assign busy_out = (state_q == hss_pkg::HSS_RUN);
   assign done_out = (state_q == hss_pkg::HSS_DONE);
   assign error_out = (state_q == hss_pkg::HSS_FAULT);

endmodule // hss_sequencer

// [sim/hss_sequencer_chk.sv]
// Purpose: Port checker for the homing switch sequencer
// Assumes: Sees only the sequencer ports
// Notes: Bound to the sequencer below the module
`timescale 1ns/100ps
module hss_sequencer_chk #(
   parameter int SPEED_W = 32
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic start_in,
   input wire logic [7:0] method_in,
   input wire logic [SPEED_W-1:0] fast_speed_in,
   input wire logic [SPEED_W-1:0] slow_speed_in,
   input wire logic home_sw_in,
   input wire logic pos_lim_in,
   input wire logic neg_lim_in,
   input wire logic index_in,
   input wire logic drive_en_out,
   input wire logic dir_pos_out,
   input wire logic [SPEED_W-1:0] speed_out,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic error_out
);
   wire logic pos_side = method_in inside {8'h02, 8'h12, 8'h07, 8'h08, 8'h09, 8'h0A};
   wire logic neg_side = method_in inside {8'h01, 8'h11, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
   wire logic valid_m = pos_side || neg_side;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   // Start edge accepted while not busy: idle, done or fault
   sequence s_start;
      $rose(start_in) && !busy_out;
   endsequence
   property p_first(m, lim, dir);
      s_start ##0 (method_in == m && !lim && !home_sw_in)
         |=> drive_en_out && dir_pos_out == dir && speed_out == fast_speed_in;
   endproperty
   chk_first_pos_seven: assert property (p_first(8'h07, pos_lim_in, 1'b1))
      else $error("first move of method 7 wrong");
   chk_first_neg_one: assert property (p_first(8'h01, neg_lim_in, 1'b0))
      else $error("first move of method 1 wrong");
   chk_first_pos_two: assert property (p_first(8'h02, pos_lim_in, 1'b1))
      else $error("first move of method 2 wrong");
   chk_bad_code: assert property (s_start ##0 !valid_m |=> error_out && !busy_out)
      else $error("unknown method not refused");
   chk_neg_fault: assert property (busy_out && neg_lim_in && pos_side
      |=> error_out && !drive_en_out)
      else $error("unused negative limit not flagged");
   chk_pos_fault: assert property (busy_out && pos_lim_in && neg_side
      |=> error_out && !drive_en_out)
      else $error("unused positive limit not flagged");
   chk_halt_speed: assert property (!drive_en_out |-> speed_out == {SPEED_W{1'b0}})
      else $error("speed while halted");
   chk_run_speed: assert property (drive_en_out
      |-> speed_out == fast_speed_in || speed_out == slow_speed_in)
      else $error("speed not fast or slow");
   chk_done_clean: assert property ($rose(done_out)
      |-> !drive_en_out && !busy_out && !error_out)
      else $error("done without halt");
   chk_flag_hold: assert property ((done_out || error_out) && !start_in
      |=> $stable(done_out) && $stable(error_out))
      else $error("status flag dropped");
endmodule // hss_sequencer_chk

bind hss_sequencer hss_sequencer_chk #(.SPEED_W(SPEED_W)) u_chk (.clk_sys_in, .resetn_in,
   .start_in, .method_in, .fast_speed_in, .slow_speed_in, .home_sw_in, .pos_lim_in,
   .neg_lim_in, .index_in, .drive_en_out, .dir_pos_out, .speed_out, .busy_out, .done_out,
   .error_out);

// [sim/hss_axis_model.sv]
// Purpose: Axis model with home switch, end limits and index marks
// Assumes: One count of travel per cycle while drive is enabled
// Notes: Trip inputs force a limit when the bench commands it
`timescale 1ns/100ps
module hss_axis_model #(
   parameter int HOME_LO = 20,
   parameter int HOME_HI = 40,
   parameter int END_POS = 100
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic drive_en_in,
   input wire logic dir_pos_in,
   input wire logic fast_in,
   input wire logic load_in,
   input wire logic signed [31:0] load_pos_in,
   input wire logic neg_trip_in,
   input wire logic pos_trip_in,
   output logic home_sw_out,
   output logic pos_lim_out,
   output logic neg_lim_out,
   output logic index_out,
   output logic signed [31:0] halt_pos_out,
   output logic last_fast_out
);
   logic signed [31:0] pos_q;
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pos_q <= 32'sh0;
         halt_pos_out <= 32'sh0;
         last_fast_out <= 1'b0;
      end else if (load_in) begin
         pos_q <= load_pos_in;
      end else if (drive_en_in) begin
         halt_pos_out <= pos_q;
         last_fast_out <= fast_in;
         pos_q <= dir_pos_in ? pos_q + 32'sh1 : pos_q - 32'sh1;
      end
   end
   assign home_sw_out = (pos_q >= HOME_LO) && (pos_q <= HOME_HI);
   assign pos_lim_out = (pos_q >= END_POS) || pos_trip_in;
   assign neg_lim_out = (pos_q <= -END_POS) || neg_trip_in;
   assign index_out = (pos_q[3:0] == 4'h0);
endmodule // hss_axis_model

// [sim/hss_sequencer_tb.sv]
// Purpose: Self-checking bench for the homing switch sequencer
// Assumes: Axis model stands in for switches and index
// Notes: Halt position per method is fixed by the model layout
`timescale 1ns/100ps
module hss_sequencer_tb;
   logic clk_sys_in, resetn_in, start_in, load_in, neg_trip_in, pos_trip_in;
   logic home_sw_in, pos_lim_in, neg_lim_in, index_in, drive_en_out, dir_pos_out;
   logic busy_out, done_out, error_out, last_fast;
   logic [7:0] method_in;
   logic [31:0] fast_speed_in, slow_speed_in, speed_out, rng_q;
   logic signed [31:0] load_pos_in, halt_pos;
   logic [7:0] codes [12] = '{8'h01, 8'h02, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
      8'h0D, 8'h0E, 8'h11, 8'h12};
   int n_mismatch, comparisons;
   wire logic fast_w = (speed_out == fast_speed_in);
   hss_sequencer #(.SPEED_W(32)) dut (.clk_sys_in, .resetn_in, .start_in, .method_in,
      .fast_speed_in, .slow_speed_in, .home_sw_in, .pos_lim_in, .neg_lim_in, .index_in,
      .drive_en_out, .dir_pos_out, .speed_out, .busy_out, .done_out, .error_out);
   hss_axis_model model (.clk_sys_in, .resetn_in, .drive_en_in(drive_en_out),
      .dir_pos_in(dir_pos_out), .fast_in(fast_w), .load_in, .load_pos_in, .neg_trip_in,
      .pos_trip_in, .home_sw_out(home_sw_in), .pos_lim_out(pos_lim_in),
      .neg_lim_out(neg_lim_in), .index_out(index_in), .halt_pos_out(halt_pos),
      .last_fast_out(last_fast));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Where the axis halts for each method
   function automatic logic signed [31:0] home_pos(input logic [7:0] m);
      case (m)
         8'h01: return -32'sh60;
         8'h02: return 32'sh60;
         8'h07, 8'h0E: return 32'sh10;
         8'h08, 8'h09, 8'h0C, 8'h0D: return 32'sh20;
         8'h0A, 8'h0B: return 32'sh30;
         8'h11: return -32'sh63;
         default: return 32'sh63;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wait_end(input int lim);
      int i;
      for (i = 0; i < lim && done_out !== 1'b1 && error_out !== 1'b1; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
      if (done_out !== 1'b1 && error_out !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
   endtask
   // Start a run, with an ignored start edge early in it
   task automatic launch(input logic [7:0] m, input logic signed [31:0] p);
      @(posedge clk_sys_in);
      rng_q = next_rand(rng_q);
      start_in <= 1'b0;
      load_in <= 1'b1;
      load_pos_in <= p;
      method_in <= m;
      fast_speed_in <= {16'h0001, rng_q[15:0]};
      slow_speed_in <= {16'h0000, rng_q[31:16]};
      @(posedge clk_sys_in);
      load_in <= 1'b0;
      start_in <= 1'b1;
      @(posedge clk_sys_in);
      start_in <= 1'b0;
      @(posedge clk_sys_in);
      start_in <= 1'b1;
   endtask
   task automatic run_home(input logic [7:0] m, input logic signed [31:0] p);
      launch(m, p);
      wait_end(1000);
      check({31'h0, done_out}, 32'h1);
      check({31'h0, error_out}, 32'h0);
      check(halt_pos, home_pos(m));
      check({31'h0, last_fast}, 32'h0);
   endtask
   task automatic trip(input logic [7:0] m, input logic neg);
      launch(m, 32'sh0);
      repeat (3) @(posedge clk_sys_in);
      neg_trip_in <= neg;
      pos_trip_in <= !neg;
      @(posedge clk_sys_in);
      neg_trip_in <= 1'b0;
      pos_trip_in <= 1'b0;
      wait_end(4);
      check({31'h0, error_out}, 32'h1);
      check({31'h0, drive_en_out}, 32'h0);
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      int i;
      n_mismatch = 0;
      comparisons = 0;
      resetn_in = 1'b0;
      start_in = 1'b0;
      load_in = 1'b0;
      load_pos_in = 32'sh0;
      method_in = 8'h07;
      fast_speed_in = 32'h0000_0100;
      slow_speed_in = 32'h0000_0010;
      neg_trip_in = 1'b0;
      pos_trip_in = 1'b0;
      rng_q = 32'h0000_74E6;
      repeat (2) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      run_home(8'h07, 32'sh1E);
      run_home(8'h07, 32'sh3C);
      run_home(8'h01, -32'sh64);
      run_home(8'h02, 32'sh64);
      foreach (codes[k]) run_home(codes[k], -32'sh32);
      for (i = 0; i < 24; i++) begin
         rng_q = next_rand(rng_q);
         run_home(codes[rng_q[20:8] % 13'h00C], 32'(rng_q[7:0] % 8'hBF) - 32'sh5F);
      end
      launch(8'h03, 32'sh0);
      wait_end(4);
      check({31'h0, error_out}, 32'h1);
      check({31'h0, done_out}, 32'h0);
      trip(8'h07, 1'b1);
      trip(8'h0B, 1'b0);
      launch(8'h07, 32'sh0);
      repeat (3) @(posedge clk_sys_in);
      resetn_in <= 1'b0;
      start_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
      check({30'h0, busy_out, drive_en_out}, 32'h0);
      @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      run_home(8'h0C, 32'sh24);
      close_out();
   end
endmodule // hss_sequencer_tb
